// >>> rtl/tlr_top.sv
/*
 * timer command decode, per-counter setup, count writes and read-back
 * port for three counters on an 8-bit i/o port bus.
 * assumes io strobes are one-cycle pulses on clk and the counting core
 * runs on clk; counter out pins arrive asynchronously.
 */
`timescale 1ns/1ps
`default_nettype none
//Contract
// - command word with top bits 11 is a read-back command
// - read-back bit 5 zero latches count of selected counters
// - read-back bit 4 zero latches status of selected counters
// - bits 3,2,1 select counters 2,1,0; unselected are untouched
// - with status and count latched, reads return both in turn
// - captured status is returned by the next read of that counter's port
// - command with bits 5:4 00 latches counter chosen by bits 7:6
// - count latch captures present value; counter keeps running
// - latch while an unread latch is held is ignored
// - each counter keeps its own byte sequence
// - status bit 7 shows the out pin level at capture
// - status bit 6 set until written count reaches counting element
// - status bits 5:4 echo programmed read/write selection
// - status bits 3:1 echo programmed counting mode
// - status bit 0 shows binary or decimal countdown
// - status bit 7 is zero after reset
// - counters 0,1,2 read at ports 40h, 41h, 42h
// - access port also writes the 16-bit count in programmed order
module tlr_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    input wire logic [tlr_pkg::NUM_CNT-1:0][15:0] elem_count,
    input wire logic [tlr_pkg::NUM_CNT-1:0] elem_loaded,
    input wire logic [tlr_pkg::NUM_CNT-1:0] out_pin,
    output logic [tlr_pkg::NUM_CNT-1:0][15:0] hold_value,
    output logic [tlr_pkg::NUM_CNT-1:0] hold_load,
    output logic [tlr_pkg::NUM_CNT-1:0][2:0] cnt_mode,
    output logic [tlr_pkg::NUM_CNT-1:0][1:0] cnt_rw,
    output logic [tlr_pkg::NUM_CNT-1:0] cnt_bcd
);
    import tlr_pkg::*;

    // one-hot counter port decode, used for both reads and writes
    function automatic logic [NUM_CNT-1:0] port_hit(input logic [7:0] addr);
        logic [NUM_CNT-1:0] hit;
        hit = '0;
        unique case (addr)
            ADDR_CNT0: hit = 3'h1;
            ADDR_CNT1: hit = 3'h2;
            ADDR_CNT2: hit = 3'h4;
            default: hit = 3'h0;
        endcase
        return hit;
    endfunction : port_hit

    logic cmd_wr;
    logic cmd_readback;
    logic cmd_latch;
    logic cmd_setup;
    logic [1:0] cmd_sel;
    logic [NUM_CNT-1:0] rd_hit;
    logic [NUM_CNT-1:0] wr_hit;
    logic [NUM_CNT-1:0] setup_hit;
    logic [NUM_CNT-1:0] latch_cnt;
    logic [NUM_CNT-1:0] latch_sts;
    logic [NUM_CNT-1:0] out_lvl;
    logic [NUM_CNT-1:0][7:0] sts_live;
    logic [NUM_CNT-1:0][7:0] rd_byte;

    logic [NUM_CNT-1:0][2:0] mode_q;
    logic [NUM_CNT-1:0][1:0] rw_q;
    logic [NUM_CNT-1:0] bcd_q;
    logic [NUM_CNT-1:0] null_q;
    tlr_seq_type [NUM_CNT-1:0] wseq_q;
    logic [NUM_CNT-1:0][7:0] lsb_hold_q;
    logic [NUM_CNT-1:0][15:0] hold_q;
    logic [NUM_CNT-1:0] load_q;
    logic [7:0] rdata_q;
    logic rvalid_q;

    // command word decode
    assign cmd_wr = ce && io_wr && (io_addr == ADDR_CMD);
    assign cmd_sel = io_wdata[CW_SEL_LO +: 2];
    assign cmd_readback = cmd_wr && (cmd_sel == SEL_READBACK);
    assign cmd_latch = cmd_wr && (cmd_sel != SEL_READBACK)
        && (io_wdata[CW_RW_LO +: 2] == RW_LATCH);
    assign cmd_setup = cmd_wr && (cmd_sel != SEL_READBACK)
        && (io_wdata[CW_RW_LO +: 2] != RW_LATCH);

    assign rd_hit = (ce && io_rd) ? port_hit(io_addr) : '0;
    assign wr_hit = (ce && io_wr) ? port_hit(io_addr) : '0;

    // pins are asynchronous to clk
    tlr_sync #(
        .WIDTH(NUM_CNT)
    ) u_out_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pin(out_pin),
        .level(out_lvl)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
            assign setup_hit[gi] = cmd_setup && (cmd_sel == 2'(gi));
            assign latch_cnt[gi] = (cmd_readback && !io_wdata[RB_NO_COUNT]
                && io_wdata[RB_SEL_LO + gi])
                || (cmd_latch && (cmd_sel == 2'(gi)));
            assign latch_sts[gi] = cmd_readback && !io_wdata[RB_NO_STATUS]
                && io_wdata[RB_SEL_LO + gi];

            // status byte as it stands this cycle
            assign sts_live[gi][ST_OUT] = out_lvl[gi];
            assign sts_live[gi][ST_NULL] = null_q[gi];
            assign sts_live[gi][5:4] = rw_q[gi];
            assign sts_live[gi][3:1] = mode_q[gi];
            assign sts_live[gi][0] = bcd_q[gi];

            tlr_chan u_chan (
                .clk(clk),
                .rst(rst),
                .ce(ce),
                .cfg_wr(setup_hit[gi]),
                .latch_cnt(latch_cnt[gi]),
                .latch_sts(latch_sts[gi]),
                .rd(rd_hit[gi]),
                .rw(rw_q[gi]),
                .cnt_in(elem_count[gi]),
                .sts_in(sts_live[gi]),
                .rd_byte(rd_byte[gi])
            );
        end
    endgenerate

    // per-counter setup: mode, access order, countdown type
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                mode_q[i] <= RST_MODE;
                rw_q[i] <= RST_RW;
                bcd_q[i] <= 1'b0;
            end
        end else if (ce) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                if (setup_hit[i]) begin
                    mode_q[i] <= io_wdata[CW_MODE_LO +: 3];
                    rw_q[i] <= io_wdata[CW_RW_LO +: 2];
                    bcd_q[i] <= io_wdata[CW_BCD];
                end
            end
        end
    end

    // count writes through the access port in the programmed order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                wseq_q[i] <= SEQ_LOW;
                lsb_hold_q[i] <= BYTE_ZERO;
                hold_q[i] <= RST_COUNT;
                load_q[i] <= 1'b0;
            end
        end else if (ce) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                load_q[i] <= 1'b0;
                if (setup_hit[i]) begin
                    wseq_q[i] <= SEQ_LOW;
                end else if (wr_hit[i]) begin
                    unique case (rw_q[i])
                        RW_LSB: begin
                            hold_q[i] <= {BYTE_ZERO, io_wdata};
                            load_q[i] <= 1'b1;
                        end
                        RW_MSB: begin
                            hold_q[i] <= {io_wdata, BYTE_ZERO};
                            load_q[i] <= 1'b1;
                        end
                        RW_BOTH: begin
                            if (wseq_q[i] == SEQ_LOW) begin
                                lsb_hold_q[i] <= io_wdata;
                                wseq_q[i] <= SEQ_HIGH;
                            end else begin
                                hold_q[i] <= {io_wdata, lsb_hold_q[i]};
                                load_q[i] <= 1'b1;
                                wseq_q[i] <= SEQ_LOW;
                            end
                        end
                        RW_LATCH: begin
                            // reset value only, never programmed: writes have no byte order
                            load_q[i] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    // pending transfer flag; a new write wins over a same-cycle transfer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            null_q <= '0;
        end else if (ce) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                if (setup_hit[i] || load_q[i]) begin
                    null_q[i] <= 1'b1;
                end else if (elem_loaded[i]) begin
                    null_q[i] <= 1'b0;
                end
            end
        end
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= RST_STATUS;
            rvalid_q <= 1'b0;
        end else if (ce) begin
            rvalid_q <= io_rd;
            if (io_rd) begin
                unique case (rd_hit)
                    3'h1: rdata_q <= rd_byte[0];
                    3'h2: rdata_q <= rd_byte[1];
                    3'h4: rdata_q <= rd_byte[2];
                    default: rdata_q <= RD_UNMAPPED;
                endcase
            end
        end
    end

    assign io_rdata = rdata_q;
    assign io_rvalid = rvalid_q;
    assign hold_value = hold_q;
    assign hold_load = load_q;
    assign cnt_mode = mode_q;
    assign cnt_rw = rw_q;
    assign cnt_bcd = bcd_q;
endmodule : tlr_top
`default_nettype wire

// >>> rtl/tlr_pkg.sv
/*
 * constants and types shared by the timer latch and read-back logic.
 * assumes an 8-bit i/o port bus and three 16-bit counting elements.
 */
`default_nettype none
package tlr_pkg;
    localparam int NUM_CNT = 3;
    // i/o port offsets
    localparam logic [7:0] ADDR_CNT0 = 8'h40;
    localparam logic [7:0] ADDR_CNT1 = 8'h41;
    localparam logic [7:0] ADDR_CNT2 = 8'h42;
    localparam logic [7:0] ADDR_CMD = 8'h43;
    // command word fields
    localparam int CW_SEL_LO = 6;
    localparam int CW_RW_LO = 4;
    localparam int CW_MODE_LO = 1;
    localparam int CW_BCD = 0;
    localparam int RB_NO_COUNT = 5;
    localparam int RB_NO_STATUS = 4;
    localparam int RB_SEL_LO = 1;
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] RW_LATCH = 2'h0;
    localparam logic [1:0] RW_LSB = 2'h1;
    localparam logic [1:0] RW_MSB = 2'h2;
    localparam logic [1:0] RW_BOTH = 2'h3;
    // status byte fields
    localparam int ST_OUT = 7;
    localparam int ST_NULL = 6;
    // reset and fixed values
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic [1:0] RST_RW = 2'h0;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [7:0] RD_UNMAPPED = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [0:0] {
        SEQ_LOW = 1'b0,
        SEQ_HIGH = 1'b1
    } tlr_seq_type;
endpackage : tlr_pkg
`default_nettype wire

// >>> rtl/tlr_sync.sv
/*
 * three-stage synchroniser for pin inputs; output follows once the
 * second and third stages agree. assumes free-running clk.
 */
`timescale 1ns/1ps
`default_nettype none
module tlr_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    import tlr_pkg::*;

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // filters one-cycle disagreement between the late stages
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_q <= '0;
        end else if (ce) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign level = level_q;
endmodule : tlr_sync
`default_nettype wire

// >>> rtl/tlr_chan.sv
/*
 * per-counter latch and read-back sequencer: count latch, status latch
 * and the byte order of reads. assumes one read strobe per bus cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module tlr_chan (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cfg_wr,
    input wire logic latch_cnt,
    input wire logic latch_sts,
    input wire logic rd,
    input wire logic [1:0] rw,
    input wire logic [15:0] cnt_in,
    input wire logic [7:0] sts_in,
    output logic [7:0] rd_byte
);
    import tlr_pkg::*;

    logic sts_vld_q;
    logic [7:0] sts_q;
    logic cnt_vld_q;
    logic [15:0] cnt_q;
    tlr_seq_type seq_q;
    logic [15:0] src;

    // status first, then count; both kept until read or a setup write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sts_vld_q <= 1'b0;
            sts_q <= RST_STATUS;
        end else if (ce) begin
            if (cfg_wr || (rd && sts_vld_q)) begin
                sts_vld_q <= 1'b0;
            end
            if (latch_sts && !sts_vld_q) begin
                sts_vld_q <= 1'b1;
                sts_q <= sts_in;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_vld_q <= 1'b0;
            cnt_q <= RST_COUNT;
        end else if (ce) begin
            if (cfg_wr) begin
                cnt_vld_q <= 1'b0;
            end else if (rd && !sts_vld_q && (rw != RW_BOTH || seq_q == SEQ_HIGH)) begin
                cnt_vld_q <= 1'b0;
            end
            // a pending latch holds its first value
            if (latch_cnt && !cnt_vld_q) begin
                cnt_vld_q <= 1'b1;
                cnt_q <= cnt_in;
            end
        end
    end

    // own byte pointer, untouched by other counters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_q <= SEQ_LOW;
        end else if (ce) begin
            if (cfg_wr) begin
                seq_q <= SEQ_LOW;
            end else if (rd && !sts_vld_q && rw == RW_BOTH) begin
                seq_q <= (seq_q == SEQ_LOW) ? SEQ_HIGH : SEQ_LOW;
            end
        end
    end

    assign src = cnt_vld_q ? cnt_q : cnt_in;

    always_comb begin
        if (sts_vld_q) begin
            rd_byte = sts_q;
        end else if (rw == RW_MSB || (rw == RW_BOTH && seq_q == SEQ_HIGH)) begin
            rd_byte = src[15:8];
        end else begin
            rd_byte = src[7:0];
        end
    end
endmodule : tlr_chan
`default_nettype wire

// >>> verif/tlr_props.sv
/* assertions on the timer read-back port.
   assumes binding to tlr_top, ce mostly high. */
`timescale 1ns/1ps
`default_nettype none
module tlr_props
import tlr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rvalid,
    input wire logic [NUM_CNT-1:0][15:0] hold_value,
    input wire logic [NUM_CNT-1:0] hold_load,
    input wire logic [NUM_CNT-1:0][2:0] cnt_mode,
    input wire logic [NUM_CNT-1:0][1:0] cnt_rw,
    input wire logic [NUM_CNT-1:0] cnt_bcd
);
    logic cmd_wr;
    logic rd_go;
    assign cmd_wr = ce && io_wr && io_addr == ADDR_CMD;
    assign rd_go = ce && io_rd;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_setup0_both;
        cmd_wr && io_wdata[7:4] == 4'h3;
    endsequence
    sequence s_wr0;
        ce && io_wr && io_addr == ADDR_CNT0;
    endsequence
    a_count_write: assert property (s_setup0_both ##1 s_wr0 ##1 s_wr0 |=>
        hold_load[0] && hold_value[0] == {$past(io_wdata), $past(io_wdata, 2)})
        else $error("count write not assembled");
    a_rvalid_after: assert property (rd_go |=> io_rvalid)
        else $error("no read answer");
    a_rvalid_only: assert property (!rd_go |=> !io_rvalid)
        else $error("spurious read answer");
    a_unmapped_read: assert property (rd_go && io_addr[7:2] != 6'h10 |=> io_rdata == RD_UNMAPPED)
        else $error("unmapped read not FF");
    a_rdata_hold: assert property (!rd_go |=> $stable(io_rdata))
        else $error("read data moved without read");
    a_setup_echo: assert property (cmd_wr && io_wdata[7:6] == 2'h0 && io_wdata[5:4] != RW_LATCH |=>
        cnt_rw[0] == $past(io_wdata[5:4]) && cnt_mode[0] == $past(io_wdata[3:1])
        && cnt_bcd[0] == $past(io_wdata[0]))
        else $error("setup not echoed");
    a_latch_keeps: assert property (cmd_wr && io_wdata[5:4] == RW_LATCH && io_wdata[7:6] != SEL_READBACK
        |=> $stable(cnt_rw) && $stable(cnt_mode))
        else $error("latch command changed setup");
    a_readback_keeps: assert property (cmd_wr && io_wdata[7:6] == SEL_READBACK |=>
        $stable(cnt_rw) && $stable(cnt_mode) && $stable(cnt_bcd))
        else $error("read-back changed setup");
endmodule : tlr_props
bind tlr_top tlr_props u_props (.clk(clk), .rst(rst), .ce(ce), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .hold_value(hold_value), .hold_load(hold_load), .cnt_mode(cnt_mode), .cnt_rw(cnt_rw),
    .cnt_bcd(cnt_bcd));
`default_nettype wire

// >>> verif/tlr_core_model.sv
/* counting elements behind the latch logic.
   assumes the same clk; loads a written count 3 cycles later. */
`timescale 1ns/1ps
`default_nettype none
module tlr_core_model
import tlr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [NUM_CNT-1:0][15:0] hold_value,
    input wire logic [NUM_CNT-1:0] hold_load,
    output logic [NUM_CNT-1:0][15:0] elem_count,
    output logic [NUM_CNT-1:0] elem_loaded
);
    logic [NUM_CNT-1:0][2:0] dly_q;
    // slow transfer so the pending flag is visible for a while
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dly_q <= '0;
        end else if (ce) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                dly_q[i] <= {dly_q[i][1:0], hold_load[i]};
            end
        end
    end
    always_comb begin
        for (int i = 0; i < NUM_CNT; i++) begin
            elem_loaded[i] = dly_q[i][2];
        end
    end
    // counts down every cycle it does not load, so every latch sees a new value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            elem_count <= '0;
        end else if (ce) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                elem_count[i] <= elem_loaded[i] ? hold_value[i] : elem_count[i] - 16'h0001;
            end
        end
    end
endmodule : tlr_core_model
`default_nettype wire

// >>> verif/test_timer_latch_readback.sv
/* self-checking bench for the timer latch and read-back port.
   assumes tlr_top and the counting element model. */
`timescale 1ns/1ps
`default_nettype none
module test_timer_latch_readback;
    import tlr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_addr = 8'h00;
    logic [7:0] io_wdata = 8'h00;
    logic [NUM_CNT-1:0] out_pin = 3'h0;
    logic [7:0] io_rdata;
    logic io_rvalid;
    logic [NUM_CNT-1:0][15:0] elem_count;
    logic [NUM_CNT-1:0][15:0] hold_value;
    logic [NUM_CNT-1:0] elem_loaded;
    logic [NUM_CNT-1:0] hold_load;
    logic [NUM_CNT-1:0] cnt_bcd;
    logic [NUM_CNT-1:0][2:0] cnt_mode;
    logic [NUM_CNT-1:0][1:0] cnt_rw;
    logic [2:0] md [3] = '{3'h2, 3'h7, 3'h4};
    logic [15:0] snap;
    logic [15:0] snap2;
    int errors = 0;
    int n_checks = 0;
    always #20 clk = ~clk;
    tlr_top dut_u (.clk(clk), .rst(rst), .ce(ce), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .elem_count(elem_count),
        .elem_loaded(elem_loaded), .out_pin(out_pin), .hold_value(hold_value),
        .hold_load(hold_load), .cnt_mode(cnt_mode), .cnt_rw(cnt_rw), .cnt_bcd(cnt_bcd));
    tlr_core_model core_u (.clk(clk), .rst(rst), .ce(ce), .hold_value(hold_value),
        .hold_load(hold_load), .elem_count(elem_count), .elem_loaded(elem_loaded));
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one assignment per signal per step keeps back-to-back cycles race free
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        io_wr = w;
        io_rd = r;
        io_addr = a;
        io_wdata = d;
        @(negedge clk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
    endtask : idle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, 1'b1, a, 8'h00);
        chk("read valid", {7'h00, io_rvalid}, 8'h01);
        chk("read data", io_rdata, exp);
    endtask : rd
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        final_report();
    end
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        wr(ADDR_CMD, 8'hE2);
        rd(ADDR_CNT0, RST_STATUS);
        $display("reset status test done");
        out_pin = 3'h4;
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CMD, {i[1:0], RW_BOTH, md[i], i[0]});
            wr(ADDR_CNT0 + i[7:0], 8'h34);
            wr(ADDR_CNT0 + i[7:0], 8'h12);
            idle(1);
            wr(ADDR_CMD, 8'hE0 | (8'h02 << i));
            rd(ADDR_CNT0 + i[7:0], {out_pin[i], 1'b1, RW_BOTH, md[i], i[0]});
            idle(4);
            wr(ADDR_CMD, 8'hE0 | (8'h02 << i));
            rd(ADDR_CNT0 + i[7:0], {out_pin[i], 1'b0, RW_BOTH, md[i], i[0]});
        end
        $display("setup and status test done");
        snap = elem_count[1];
        wr(ADDR_CMD, 8'hC4);
        rd(ADDR_CNT1, {2'h0, RW_BOTH, md[1], 1'b1});
        rd(ADDR_CNT1, snap[7:0]);
        snap2 = elem_count[0];
        wr(ADDR_CMD, 8'h00);
        rd(ADDR_CNT0, snap2[7:0]);
        rd(ADDR_CNT0, snap2[15:8]);
        rd(ADDR_CNT1, snap[15:8]);
        $display("count and status test done");
        snap = elem_count[2];
        wr(ADDR_CMD, 8'h80);
        idle(3);
        wr(ADDR_CMD, 8'h80);
        rd(ADDR_CNT2, snap[7:0]);
        rd(ADDR_CNT2, snap[15:8]);
        snap = elem_count[2];
        wr(ADDR_CMD, 8'h80);
        rd(ADDR_CNT2, snap[7:0]);
        rd(ADDR_CNT2, snap[15:8]);
        $display("repeat latch test done");
        wr(ADDR_CMD, 8'hE4);
        snap = elem_count[0];
        rd(ADDR_CNT0, snap[7:0]);
        rd(ADDR_CNT1, {2'h0, RW_BOTH, md[1], 1'b1});
        rd(8'h50, RD_UNMAPPED);
        idle(1);
        ce = 1'b0;
        bus(1'b0, 1'b1, ADDR_CNT2, 8'h00);
        chk("frozen valid", {7'h00, io_rvalid}, 8'h00);
        ce = 1'b1;
        idle(1);
        $display("select test done");
        final_report();
    end
endmodule : test_timer_latch_readback
`default_nettype wire
